//--- rtl/src_pkg.sv
package src_pkg;
  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] SOFTWARE_RESET_CONTROL_OFFSET = 12'h1F8;
  localparam logic [11:0] CORE_STATUS_OFFSET = 12'h1FC;
  localparam logic [31:0] SOFTWARE_RESET_CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DIGITAL_RESET_POS = 0;
  localparam int FIRST_PORT_PHY_RESET_POS = 1;
  localparam int SECOND_PORT_PHY_RESET_POS = 2;
  localparam int VIRTUAL_PHY_RESET_POS = 3;
  localparam int READY_POS = 0;
  localparam int SOFT_RESET_IMMUNE_TYPE_POS = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 40000000;
  localparam int PHY_HOLD_NS = 102000;
  localparam int PHY_HOLD_CYCLES = (PHY_HOLD_NS * 40 + 999) / 1000;
  localparam int VPHY_HOLD_CYCLES = 4;
  localparam int CORE_HOLD_CYCLES = 16;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_HOLD = 2'b01,
    SRC_DONE = 2'b10
  } src_hold_state_t;
endpackage

//--- rtl/src_hold_if.sv
`timescale 1ns/100ps
interface src_hold_if;
  logic start;
  logic [src_pkg::CNT_W-1:0] cycles;
  logic active;
  modport ctrl (output start, output cycles, input active);
  modport timer (input start, input cycles, output active);
endinterface

//--- rtl/src_hold_timer.sv
`timescale 1ns/100ps
module src_hold_timer (
  input wire clk,
  input wire nrst,
  src_hold_if.timer hold
);
  import src_pkg::*;

  src_hold_state_t state;
  src_hold_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // counter loaded on set, clocked from core clock
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      SRC_IDLE: begin
        if (hold.start) begin
          next_state = SRC_HOLD;
          next_count = hold.cycles;
        end
      end
      SRC_HOLD: begin
        if (count <= CNT_ONE) begin
          next_state = SRC_DONE;
          next_count = CNT_ZERO;
        end else begin
          next_count = count - CNT_ONE;
        end
      end
      SRC_DONE: begin
        next_state = SRC_IDLE;
      end
      default: begin
        next_state = SRC_IDLE;
        next_count = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= SRC_IDLE;
      count <= CNT_ZERO;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign hold.active = (state == SRC_HOLD) || hold.start;
endmodule

//--- rtl/src_top.sv
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
// Overview of operation
// (R1) bit 3 resets virtual phy, self-clears when it leaves reset
// (R2) bit 2 resets second phy at least 102us, then self-clears
// (R3) bit 1 resets first phy at least 102us, then self-clears
// (R4) writes to a set self-clearing bit are ignored
// (R5) bit 0 resets whole core except pll and the three phys
// (R6) after core reset the loader reloads eeprom, phys untouched
// (R7) core reset returns csrs to defaults except immune bits
// (R8) core reset aborts any eeprom command in progress
// (R9) bit 0 self-clears on release; host polls it
// (R10) host reads device once before trusting its writes
// (R11) reset control register answers reads during reset and not ready
// (R12) eeprom loader cannot write the reset control bits
// (R13) other resources refuse reads and writes while not ready; here only status writes are refused, reads are always answered
// (R14) phy hold time counted on core clock, loaded on set
// (R15) bits 31 to 4 read zero, writes ignored
module src_top (
  input wire clk,
  input wire nrst,
  input wire [src_pkg::ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [src_pkg::DATA_W-1:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output logic [src_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire loader_done,
  output logic virtual_phy_reset,
  output logic first_port_phy_reset,
  output logic second_port_phy_reset,
  output logic core_reset,
  output logic config_reload,
  output logic eeprom_abort,
  output logic device_ready,
  output logic soft_reset_immune_type
);
  import src_pkg::*;

  // ****************************************************************
  // hold timers
  // ****************************************************************
  src_hold_if h_vphy();
  src_hold_if h_phy1();
  src_hold_if h_phy2();
  src_hold_if h_core();

  src_hold_timer u_vphy (.clk(clk), .nrst(nrst), .hold(h_vphy));
  src_hold_timer u_phy1 (.clk(clk), .nrst(nrst), .hold(h_phy1));
  src_hold_timer u_phy2 (.clk(clk), .nrst(nrst), .hold(h_phy2));
  src_hold_timer u_core (.clk(clk), .nrst(nrst), .hold(h_core));

  // ****************************************************************
  // register state
  // ****************************************************************
  logic virtual_phy_reset_bit;
  logic first_port_phy_reset_bit;
  logic second_port_phy_reset_bit;
  logic digital_reset_bit;
  logic ready;
  logic immune;
  logic read_seen;
  logic ack;
  logic [DATA_W-1:0] rdata;
  logic next_virtual_phy_reset_bit;
  logic next_first_port_phy_reset_bit;
  logic next_second_port_phy_reset_bit;
  logic next_digital_reset_bit;
  logic next_ready;
  logic next_immune;
  logic next_read_seen;
  logic next_ack;
  logic [DATA_W-1:0] next_rdata;
  logic core_was_active;
  logic next_core_was_active;

  logic req;
  logic wr_low;
  logic hit_ctl;
  logic hit_status;
  logic set_vphy;
  logic set_phy1;
  logic set_phy2;
  logic set_core;
  logic core_release;

  assign req = (avs_read || avs_write) && !ack;
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_low = avs_write && ack && avs_byteenable[0];
  assign hit_ctl = (avs_address == SOFTWARE_RESET_CONTROL_OFFSET);
  assign hit_status = (avs_address == CORE_STATUS_OFFSET);

  // only the bus port can write here, the loader has no path
  // (R12) host only access
  // (R4) ignore while set
  assign set_vphy = wr_low && hit_ctl && !virtual_phy_reset_bit && avs_writedata[VIRTUAL_PHY_RESET_POS];
  assign set_phy1 = wr_low && hit_ctl && !first_port_phy_reset_bit && avs_writedata[FIRST_PORT_PHY_RESET_POS];
  assign set_phy2 = wr_low && hit_ctl && !second_port_phy_reset_bit && avs_writedata[SECOND_PORT_PHY_RESET_POS];
  // (R10) core write ignored until a first read
  assign set_core = wr_low && hit_ctl && !digital_reset_bit && avs_writedata[DIGITAL_RESET_POS] && read_seen;

  // (R14) load hold counters
  assign h_vphy.start = set_vphy;
  assign h_vphy.cycles = CNT_W'(VPHY_HOLD_CYCLES);
  assign h_phy1.start = set_phy1;
  assign h_phy1.cycles = CNT_W'(PHY_HOLD_CYCLES);
  assign h_phy2.start = set_phy2;
  assign h_phy2.cycles = CNT_W'(PHY_HOLD_CYCLES);
  assign h_core.start = set_core;
  assign h_core.cycles = CNT_W'(CORE_HOLD_CYCLES);

  assign core_release = core_was_active && !h_core.active;

  always_comb begin
    next_virtual_phy_reset_bit = virtual_phy_reset_bit;
    next_first_port_phy_reset_bit = first_port_phy_reset_bit;
    next_second_port_phy_reset_bit = second_port_phy_reset_bit;
    next_digital_reset_bit = digital_reset_bit;
    next_ready = ready;
    next_immune = immune;
    next_read_seen = read_seen;
    next_ack = 1'b0;
    next_rdata = rdata;
    next_core_was_active = h_core.active;

    // (R1) vphy self-clear
    if (set_vphy) begin
      next_virtual_phy_reset_bit = 1'b1;
    end else if (!h_vphy.active) begin
      next_virtual_phy_reset_bit = 1'b0;
    end
    // (R3) phy1 self-clear
    if (set_phy1) begin
      next_first_port_phy_reset_bit = 1'b1;
    end else if (!h_phy1.active) begin
      next_first_port_phy_reset_bit = 1'b0;
    end
    // (R2) phy2 self-clear
    if (set_phy2) begin
      next_second_port_phy_reset_bit = 1'b1;
    end else if (!h_phy2.active) begin
      next_second_port_phy_reset_bit = 1'b0;
    end
    // (R9) digital bit self-clear on release
    if (set_core) begin
      next_digital_reset_bit = 1'b1;
      next_ready = 1'b0;
    end else if (core_release) begin
      next_digital_reset_bit = 1'b0;
    end

    // (R6) ready returns once the reload completes
    if (!digital_reset_bit && !ready && loader_done && !config_reload) begin
      next_ready = 1'b1;
    end
    // (R7) csr defaults on core reset, immune bit kept
    if (set_core) begin
      next_read_seen = 1'b0;
    end

    if (req) begin
      next_ack = 1'b1;
      if (avs_read) begin
        next_read_seen = !set_core;
        // (R11) readable in reset
        if (hit_ctl) begin
          next_rdata = UNMAPPED_READ_VALUE;
          // (R15) upper bits zero
          next_rdata[VIRTUAL_PHY_RESET_POS] = virtual_phy_reset_bit;
          next_rdata[SECOND_PORT_PHY_RESET_POS] = second_port_phy_reset_bit;
          next_rdata[FIRST_PORT_PHY_RESET_POS] = first_port_phy_reset_bit;
          next_rdata[DIGITAL_RESET_POS] = digital_reset_bit;
        end else if (hit_status) begin
          next_rdata = UNMAPPED_READ_VALUE;
          next_rdata[READY_POS] = ready;
          next_rdata[SOFT_RESET_IMMUNE_TYPE_POS] = immune;
        end else begin
          next_rdata = UNMAPPED_READ_VALUE;
        end
      end
    end
    // (R13) status write refused until ready
    if (wr_low && hit_status && ready && read_seen) begin
      next_immune = avs_writedata[SOFT_RESET_IMMUNE_TYPE_POS];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      virtual_phy_reset_bit <= 1'b0;
      first_port_phy_reset_bit <= 1'b0;
      second_port_phy_reset_bit <= 1'b0;
      digital_reset_bit <= 1'b0;
      ready <= 1'b0;
      immune <= 1'b0;
      read_seen <= 1'b0;
      ack <= 1'b0;
      rdata <= SOFTWARE_RESET_CONTROL_RESET;
      core_was_active <= 1'b0;
    end else begin
      virtual_phy_reset_bit <= next_virtual_phy_reset_bit;
      first_port_phy_reset_bit <= next_first_port_phy_reset_bit;
      second_port_phy_reset_bit <= next_second_port_phy_reset_bit;
      digital_reset_bit <= next_digital_reset_bit;
      ready <= next_ready;
      immune <= next_immune;
      read_seen <= next_read_seen;
      ack <= next_ack;
      rdata <= next_rdata;
      core_was_active <= next_core_was_active;
    end
  end

  // ****************************************************************
  // reload and abort pulses
  // ****************************************************************
  logic reload_q;
  logic next_reload_q;
  logic abort_q;
  logic next_abort_q;

  always_comb begin
    next_reload_q = reload_q;
    // (R8) abort eeprom on core reset
    next_abort_q = set_core;
    // (R6) reload after core reset
    if (core_release) begin
      next_reload_q = 1'b1;
    end else if (loader_done) begin
      next_reload_q = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reload_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      reload_q <= next_reload_q;
      abort_q <= next_abort_q;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // (R5) core reset spares the phys
  assign core_reset = digital_reset_bit;
  assign virtual_phy_reset = virtual_phy_reset_bit;
  assign first_port_phy_reset = first_port_phy_reset_bit;
  assign second_port_phy_reset = second_port_phy_reset_bit;
  assign config_reload = reload_q;
  assign eeprom_abort = abort_q;
  assign device_ready = ready;
  assign soft_reset_immune_type = immune;
  assign avs_readdata = rdata;
  // answer one cycle after request; holds master until then
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
endmodule

//--- bench/src_loader_model.sv
`timescale 1ns/100ps
module src_loader_model (
  input wire clk,
  input wire nrst,
  input wire config_reload,
  output logic loader_done
);
  logic [3:0] cnt;
  logic seen;
  logic done_q;
  logic restart;
  // a new reload request restarts the load
  // done is a level; it drops at once when a new reload starts, so a stale done cannot end it
  assign restart = config_reload && !seen;
  assign loader_done = done_q && !restart;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      seen <= 1'b0;
      done_q <= 1'b0;
    end else begin
      seen <= config_reload;
      cnt <= restart ? 4'h0 : ((cnt == 4'h8) ? cnt : cnt + 4'h1);
      done_q <= !restart && (cnt == 4'h8);
    end
  end
endmodule

//--- bench/src_top_sva.sv
`timescale 1ns/100ps
module src_top_sva
  import src_pkg::*;
(
  input wire clk,
  input wire nrst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [DATA_W-1:0] avs_readdata,
  input wire avs_waitrequest,
  input wire virtual_phy_reset,
  input wire first_port_phy_reset,
  input wire second_port_phy_reset,
  input wire core_reset,
  input wire config_reload,
  input wire eeprom_abort
);
  logic [CNT_W-1:0] c1;
  logic [CNT_W-1:0] c2;
  // cycles each port phy reset has been held so far
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c1 <= CNT_ZERO;
      c2 <= CNT_ZERO;
    end else begin
      c1 <= first_port_phy_reset ? c1 + CNT_ONE : CNT_ZERO;
      c2 <= second_port_phy_reset ? c2 + CNT_ONE : CNT_ZERO;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bus_ack_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  a_phy1_hold_min: assert property ($fell(first_port_phy_reset) |-> c1 >= PHY_HOLD_CYCLES)
    else $error("first phy reset released early");
  a_phy2_hold_min: assert property ($fell(second_port_phy_reset) |-> c2 >= PHY_HOLD_CYCLES)
    else $error("second phy reset released early");
  a_vphy_hold_len: assert property ($rose(virtual_phy_reset) |-> virtual_phy_reset [*4] ##[1:20] !virtual_phy_reset)
    else $error("virtual phy reset length wrong");
  a_core_hold_len: assert property ($rose(core_reset) |-> core_reset [*8] ##[1:40] !core_reset)
    else $error("core reset length wrong");
  a_abort_pulse_core: assert property (eeprom_abort |-> core_reset ##1 !eeprom_abort)
    else $error("abort pulse not tied to core reset");
  a_reload_after_core: assert property ($fell(core_reset) |-> ##[0:2] config_reload)
    else $error("no reload after core reset");
  a_reserved_read_zero: assert property (avs_read && !avs_waitrequest && avs_address == SOFTWARE_RESET_CONTROL_OFFSET
    |-> avs_readdata[31:4] == 28'h0000000)
    else $error("reserved control bits not zero");
  c_phy1: cover property ($fell(first_port_phy_reset));
  c_core: cover property ($fell(core_reset));
  c_abort: cover property (eeprom_abort);
endmodule
bind src_top src_top_sva chk (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .virtual_phy_reset(virtual_phy_reset), .first_port_phy_reset(first_port_phy_reset),
  .second_port_phy_reset(second_port_phy_reset), .core_reset(core_reset), .config_reload(config_reload),
  .eeprom_abort(eeprom_abort));

//--- bench/src_top_tb.sv
`timescale 1ns/100ps
module src_top_tb;
  import src_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} src_row_t;
  logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, loader_done, vphy, p1, p2, core, reload, abort, ready, immune;
  int err_total = 0, check_count = 0, aborts = 0, p1_cnt = 0, p2_cnt = 0;
  src_row_t rows[7] = '{'{0, 12'h1F8, 0, 0}, '{1, 12'h1FC, 2, 0}, '{0, 12'h1FC, 0, 3},
    '{1, 12'h100, 32'hFFFFFFFF, 0}, '{0, 12'h100, 0, 0}, '{1, 12'h1F8, 32'hF0, 0}, '{0, 12'h1F8, 0, 0}};
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    aborts <= aborts + (abort === 1'b1);
    p1_cnt <= p1_cnt + (p1 === 1'b1);
    p2_cnt <= p2_cnt + (p2 === 1'b1);
  end
  src_top uut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .loader_done(loader_done), .virtual_phy_reset(vphy),
    .first_port_phy_reset(p1), .second_port_phy_reset(p2), .core_reset(core), .config_reload(reload),
    .eeprom_abort(abort), .device_ready(ready), .soft_reset_immune_type(immune));
  src_loader_model ldr (.clk(clk), .nrst(nrst), .config_reload(reload), .loader_done(loader_done));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // request held until waitrequest is sampled low
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      err_total++;
      stop_test;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // bounded poll: the host learns completion by reading the bit
  task poll(input int b);
    int i;
    for (i = 0; i < 4000; i++) begin
      bus(0, SOFTWARE_RESET_CONTROL_OFFSET, 0);
      if (rd[b] === 1'b0) break;
    end
    if (i == 4000) begin
      err_total++;
      stop_test;
    end
  endtask
  task wready;
    int i;
    for (i = 0; i < 200 && ready !== 1'b1; i++) @(posedge clk);
    if (i == 200) begin
      err_total++;
      stop_test;
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 1);
    repeat (3) @(posedge clk);
    chk("core_reset before read", core, 0);
    wready;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("table read", rd, rows[i].e);
    end
    $display("register table done");
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 8);
    @(posedge clk);
    chk("virtual phy reset", vphy, 1);
    poll(3);
    chk("virtual phy released", vphy, 0);
    $display("virtual phy reset done");
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 6);
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 6);
    bus(0, SOFTWARE_RESET_CONTROL_OFFSET, 0);
    chk("write while set", rd, 6);
    poll(1);
    poll(2);
    chk("first phy held", p1_cnt >= PHY_HOLD_CYCLES, 1);
    chk("second phy held", p2_cnt >= PHY_HOLD_CYCLES, 1);
    chk("phys released", {p1, p2}, 0);
    $display("port phy reset done");
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 1);
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 1);
    bus(0, SOFTWARE_RESET_CONTROL_OFFSET, 0);
    chk("digital bit during reset", rd, 1);
    poll(0);
    wready;
    chk("eeprom aborts", aborts, 1);
    bus(0, CORE_STATUS_OFFSET, 0);
    chk("status after core reset", rd, 3);
    chk("immune pin kept", immune, 1);
    chk("reload finished", reload, 0);
    chk("phys untouched", {vphy, p1, p2}, 0);
    $display("digital reset done");
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    bus(1, SOFTWARE_RESET_CONTROL_OFFSET, 1);
    bus(0, SOFTWARE_RESET_CONTROL_OFFSET, 0);
    chk("control read before ready", {ready, rd[3:0]}, 0);
    $display("second reset done");
    stop_test;
  end
endmodule
